/* File: core/cpu_priority_level_control.sv */
// Purpose: cpu interrupt priority level and i2c2 source priorities
// Assumes: classic wishbone slave, one 10 MHz clock, sync reset
// Notes: forwarded interrupt is registered, one cycle behind inputs
//
// What this block does
// - cpu level is top bit from core config over three status bits
// - low bits give levels 0..7, with top bit set 8..15
// - low bits all ones mean level 7 or 15, user interrupts off
// - top bit set blocks every user interrupt
// - nesting disable makes the low level bits read-only to software
// - master event priority sits at bits 10..8 of i2c2 priority
// - priority code 7 highest, 1 lowest, 0 turns the source off
// - unused i2c2 priority bits read zero, writes ignored
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module cpu_priority_level_control
	import prio_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// peripheral requests
	input wire logic master_req_i,
	input wire logic slave_req_i,
	// cpu side
	input wire logic irq_take_i,
	output logic irq_o,
	output logic [2:0] irq_level_o,
	output logic irq_src_o,
	output logic [3:0] cpu_level_o,
	output logic user_block_o
);
	typedef struct packed {
		bus_st_t bus;
		logic [15:0] dat;
		logic [2:0] lvl_low;
		logic lvl_top;
		logic nest_dis;
		logic [2:0] mprio;
		logic [2:0] sprio;
		logic irq;
		logic [2:0] irq_lvl;
		logic irq_src;
	} ctl_state_t;

	ctl_state_t st_r;
	ctl_state_t st_nxt;
	prio_if pb ();

	logic req;
	logic wr_now;
	logic [3:0] level;
	logic blocked;
	logic [15:0] wd;
	logic [15:0] rd;
	logic [15:0] merged;

	prio_arbiter u_arb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pb(pb)
	);

	assign level = {st_r.lvl_top, st_r.lvl_low};
	// level 7 or above already shuts user sources out
	assign blocked = st_r.lvl_top ||
		(st_r.lvl_low == LVL_ALL_ONES);

	assign pb.mprio = st_r.mprio;
	assign pb.sprio = st_r.sprio;
	assign pb.mreq = master_req_i;
	assign pb.sreq = slave_req_i;
	assign pb.level = level;

	assign req = cyc_i && stb_i;
	// a write lands on the edge where the master sees ack
	assign wr_now = req && we_i && (st_r.bus == BUS_ACK);
	assign wd = dat_i[15:0];

	// read view of every register, unused bits as zero
	always_comb begin
		rd = 16'h0000;
		unique case (adr_i)
			STATUS_WORD_OFS: begin
				rd[LVL_LOW_POS +: 3] = st_r.lvl_low;
			end
			CORE_CONFIG_OFS: begin
				rd[LVL_TOP_POS] = st_r.lvl_top;
			end
			I2C2_PRIO_OFS: begin
				rd[MPRIO_POS +: 3] = st_r.mprio;
				rd[SPRIO_POS +: 3] = st_r.sprio;
			end
			INT_CTL_ONE_OFS: begin
				rd[NEST_DIS_POS] = st_r.nest_dis;
			end
			LEVEL_STAT_OFS: begin
				rd[3:0] = level;
				rd[4] = blocked;
				rd[5] = st_r.irq;
				rd[8:6] = st_r.irq_lvl;
				rd[9] = st_r.irq_src;
			end
			default: begin
				rd = 16'h0000;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		merged = 16'h0000;
		// bus handshake: answer one cycle after the request shows
		unique case (st_r.bus)
			BUS_IDLE: begin
				if (req) begin
					st_nxt.bus = BUS_ACK;
					st_nxt.dat = we_i ? 16'h0000 : rd;
				end
			end
			BUS_ACK: begin
				st_nxt.bus = BUS_IDLE;
			end
		endcase

		if (wr_now) begin
			unique case (adr_i)
				STATUS_WORD_OFS: begin
					merged = lane_merge({8'h00, st_r.lvl_low, 5'h00},
						wd, sel_i[1:0]);
					// nesting disabled freezes the level against software
					if (!st_r.nest_dis) begin
						st_nxt.lvl_low = merged[LVL_LOW_POS +: 3];
					end
				end
				CORE_CONFIG_OFS: begin
					merged = lane_merge({12'h000, st_r.lvl_top, 3'h0},
						wd, sel_i[1:0]);
					st_nxt.lvl_top = merged[LVL_TOP_POS];
				end
				I2C2_PRIO_OFS: begin
					merged = lane_merge({5'h00, st_r.mprio, 1'b0,
						st_r.sprio, 4'h0}, wd, sel_i[1:0]);
					// only the two fields are stored, the rest is dropped
					st_nxt.mprio = merged[MPRIO_POS +: 3];
					st_nxt.sprio = merged[SPRIO_POS +: 3];
				end
				INT_CTL_ONE_OFS: begin
					merged = lane_merge({st_r.nest_dis, 15'h0000},
						wd, sel_i[1:0]);
					st_nxt.nest_dis = merged[NEST_DIS_POS];
				end
				default: begin
					merged = 16'h0000;
				end
			endcase
		end

		// hardware raising the level on acceptance beats a software write
		if (irq_take_i && st_r.irq) begin
			st_nxt.lvl_low = st_r.irq_lvl;
		end

		st_nxt.irq = pb.fwd && !blocked;
		st_nxt.irq_lvl = pb.fwd ? pb.fwd_prio : 3'h0;
		st_nxt.irq_src = pb.fwd ? pb.fwd_src : 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '{bus: BUS_IDLE, dat: 16'h0000,
				lvl_low: LVL_LOW_RST, lvl_top: LVL_TOP_RST,
				nest_dis: NEST_DIS_RST, mprio: MPRIO_RST,
				sprio: SPRIO_RST, irq: 1'b0, irq_lvl: 3'h0,
				irq_src: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ack_o = (st_r.bus == BUS_ACK) && req;
	assign dat_o = {16'h0000, st_r.dat};
	assign irq_o = st_r.irq;
	assign irq_level_o = st_r.irq_lvl;
	assign irq_src_o = st_r.irq_src;
	assign cpu_level_o = level;
	assign user_block_o = blocked;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence rd_status_s;
		req && !we_i && adr_i == STATUS_WORD_OFS && st_r.bus == BUS_IDLE;
	endsequence
	sequence rd_prio_s;
		req && !we_i && adr_i == I2C2_PRIO_OFS && st_r.bus == BUS_IDLE;
	endsequence
	sequence wr_prio_s;
		wr_now && adr_i == I2C2_PRIO_OFS && sel_i[1:0] == 2'b11;
	endsequence
	sequence wr_top_s;
		wr_now && adr_i == CORE_CONFIG_OFS && sel_i[0];
	endsequence

	chk_top_bit_write: assert property (
		wr_top_s ##0 !irq_take_i |=>
			cpu_level_o[3] == $past(dat_i[LVL_TOP_POS]))
		else $error("core config top bit not in cpu level");
	chk_level_readback: assert property (
		rd_status_s |=> ack_o && dat_o[7:5] == $past(cpu_level_o[2:0])
			&& dat_o[4:0] == 5'h00)
		else $error("status word level bits read back wrong");
	chk_seven_blocks: assert property (
		cpu_level_o[2:0] == LVL_ALL_ONES |-> user_block_o
			##1 !irq_o)
		else $error("level seven let a user interrupt through");
	chk_top_blocks: assert property (
		cpu_level_o[3] |-> user_block_o ##1 !irq_o)
		else $error("top level bit let a user interrupt through");
	chk_nest_lock: assert property (
		wr_now && adr_i == STATUS_WORD_OFS && st_r.nest_dis
			&& !irq_take_i |=> $stable(cpu_level_o))
		else $error("status level changed while nesting disabled");
	chk_master_field: assert property (
		wr_prio_s |=> st_r.mprio == $past(dat_i[10:8]))
		else $error("master priority field not written");
	chk_slave_field: assert property (
		wr_prio_s |=> st_r.sprio == $past(dat_i[6:4]))
		else $error("slave priority field not written");
	chk_reserved_zero: assert property (
		rd_prio_s |=> ack_o && dat_o[15:11] == 5'h00 && !dat_o[7]
			&& dat_o[3:0] == 4'h0)
		else $error("unused priority bits not read as zero");
	chk_forward_level: assert property (
		irq_o |-> {1'b0, irq_level_o} > $past(cpu_level_o)
			&& irq_level_o != PRIO_OFF)
		else $error("interrupt forwarded at or below cpu level");
	chk_ack_one_cycle: assert property (
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	// source selection, seen from the registered outputs
	sequence both_pend_s;
		master_req_i && slave_req_i && st_r.mprio != PRIO_OFF
			&& st_r.sprio != PRIO_OFF;
	endsequence
	sequence rd_other_s;
		req && !we_i && st_r.bus == BUS_IDLE
			&& adr_i != STATUS_WORD_OFS && adr_i != CORE_CONFIG_OFS
			&& adr_i != I2C2_PRIO_OFS && adr_i != INT_CTL_ONE_OFS
			&& adr_i != LEVEL_STAT_OFS;
	endsequence
	sequence take_s;
		irq_o && irq_take_i;
	endsequence
	sequence wr_status_s;
		wr_now && adr_i == STATUS_WORD_OFS && sel_i[0];
	endsequence

	chk_tie_master: assert property (
		both_pend_s ##0 st_r.mprio == st_r.sprio
			##0 {1'b0, st_r.mprio} > cpu_level_o
			|=> irq_o && !irq_src_o)
		else $error("tie not given to the master event");
	chk_slave_wins: assert property (
		both_pend_s ##0 st_r.sprio > st_r.mprio
			##0 {1'b0, st_r.sprio} > cpu_level_o
			|=> irq_o && irq_src_o && irq_level_o == $past(st_r.sprio))
		else $error("higher slave priority not forwarded");
	chk_master_off: assert property (
		st_r.mprio == PRIO_OFF && !slave_req_i |=> !irq_o)
		else $error("disabled master source raised an interrupt");
	chk_slave_off: assert property (
		st_r.sprio == PRIO_OFF && !master_req_i |=> !irq_o)
		else $error("disabled slave source raised an interrupt");
	chk_status_write: assert property (
		wr_status_s ##0 !st_r.nest_dis ##0 !(irq_take_i && st_r.irq)
			|=> cpu_level_o[2:0] == $past(dat_i[LVL_LOW_POS +: 3]))
		else $error("status word write did not reach the level");
	chk_stat_read_only: assert property (
		wr_now && adr_i == LEVEL_STAT_OFS && !irq_take_i
			|=> $stable(cpu_level_o))
		else $error("write to level status changed the level");
	// an accepted interrupt moves the level up to the one just served
	chk_take_level: assert property (
		take_s |=> cpu_level_o[2:0] == $past(irq_level_o))
		else $error("accepted interrupt did not set the cpu level");
	chk_unmapped_zero: assert property (
		rd_other_s |=> ack_o && dat_o == 32'h00000000)
		else $error("unmapped address did not read as zero");
	// reset is checked with the default disable switched off
	chk_reset_state: assert property (disable iff (1'b0)
		rst_i |=> cpu_level_o == 4'h0 && !irq_o && !ack_o
			&& !user_block_o && dat_o == 32'h00000000)
		else $error("outputs not cleared by reset");
endmodule : cpu_priority_level_control

/* File: core/prio_pkg.sv */
// Purpose: constants and helpers for the cpu priority level block
// Assumes: 32-bit classic wishbone, 16-bit registers in the low half
// Notes: all offsets are byte addresses on an 8-bit address bus
package prio_pkg;
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] STATUS_WORD_OFS = 8'h00;
	localparam logic [ADR_W-1:0] CORE_CONFIG_OFS = 8'h04;
	localparam logic [ADR_W-1:0] I2C2_PRIO_OFS = 8'h08;
	localparam logic [ADR_W-1:0] INT_CTL_ONE_OFS = 8'h0c;
	localparam logic [ADR_W-1:0] LEVEL_STAT_OFS = 8'h10;

	localparam int LVL_LOW_POS = 5;
	localparam int LVL_TOP_POS = 3;
	localparam int NEST_DIS_POS = 15;
	localparam int MPRIO_POS = 8;
	localparam int SPRIO_POS = 4;

	localparam logic [2:0] LVL_LOW_RST = 3'h0;
	localparam logic LVL_TOP_RST = 1'b0;
	localparam logic NEST_DIS_RST = 1'b0;
	localparam logic [2:0] MPRIO_RST = 3'h4;
	localparam logic [2:0] SPRIO_RST = 3'h4;
	localparam logic [2:0] LVL_ALL_ONES = 3'h7;
	localparam logic [2:0] PRIO_OFF = 3'h0;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} bus_st_t;

	// byte-lane merge of a 16-bit register write
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] sel);
		lane_merge = old_v;
		if (sel[0]) begin
			lane_merge[7:0] = new_v[7:0];
		end
		if (sel[1]) begin
			lane_merge[15:8] = new_v[15:8];
		end
	endfunction : lane_merge
endpackage : prio_pkg

/* File: core/prio_if.sv */
// Purpose: carries source priorities and the forward decision
// Assumes: one clock domain
// Notes: ctl end owns the registers, arb end picks a winner
`timescale 1ns/1ns
interface prio_if;
	logic [2:0] mprio;
	logic [2:0] sprio;
	logic mreq;
	logic sreq;
	logic [3:0] level;
	logic fwd;
	logic [2:0] fwd_prio;
	logic fwd_src;

	modport ctl (
		output mprio, sprio, mreq, sreq, level,
		input fwd, fwd_prio, fwd_src
	);
	modport arb (
		input mprio, sprio, mreq, sreq, level,
		output fwd, fwd_prio, fwd_src
	);
endinterface : prio_if

/* File: core/prio_arbiter.sv */
// Purpose: picks the pending source that may interrupt the cpu
// Assumes: inputs stable within a cycle
// Notes: purely combinational, clock used only by the checks
`timescale 1ns/1ns
module prio_arbiter
	import prio_pkg::*;
(
	// clock and reset for checks
	input wire logic clk_i,
	input wire logic rst_i,
	// priority carrier
	prio_if.arb pb
);
	logic m_ok;
	logic s_ok;

	always_comb begin
		// code 000 switches a source off, others must beat the level
		m_ok = pb.mreq && (pb.mprio != PRIO_OFF) &&
			({1'b0, pb.mprio} > pb.level);
		s_ok = pb.sreq && (pb.sprio != PRIO_OFF) &&
			({1'b0, pb.sprio} > pb.level);
		pb.fwd = m_ok || s_ok;
		pb.fwd_src = 1'b0;
		pb.fwd_prio = pb.mprio;
		// on a tie the master event is served first
		if (s_ok && (!m_ok || (pb.sprio > pb.mprio))) begin
			pb.fwd_src = 1'b1;
			pb.fwd_prio = pb.sprio;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_off_never_wins: assert property (
		pb.fwd && pb.fwd_src |-> pb.sprio != PRIO_OFF && pb.sreq)
		else $error("disabled slave source was forwarded");
	chk_fwd_beats_level: assert property (
		pb.fwd |-> {1'b0, pb.fwd_prio} > pb.level)
		else $error("forwarded priority not above cpu level");
	chk_master_off_quiet: assert property (
		pb.mprio == PRIO_OFF && !pb.sreq |-> !pb.fwd)
		else $error("disabled master source was forwarded");
endmodule : prio_arbiter

/* File: verif/irq_partner.sv */
// Purpose: peripheral event sources and cpu acceptance for the bench
// Assumes: one clock, bench commands the wanted requests
// Notes: requests are plain levels, the cpu takes at most every 2nd cycle
`timescale 1ns/1ns
module irq_partner (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench commands
	input wire logic want_m_i,
	input wire logic want_s_i,
	input wire logic take_en_i,
	// device side
	input wire logic irq_i,
	output logic master_req_o,
	output logic slave_req_o,
	output logic take_o
);
	assign master_req_o = want_m_i;
	assign slave_req_o = want_s_i;
	// a gap after each take lets the new level settle before the next one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			take_o <= 1'b0;
		end else begin
			take_o <= take_en_i && irq_i && !take_o;
		end
	end
endmodule : irq_partner

/* File: verif/cpu_priority_level_control_bench.sv */
// Purpose: self-checking bench for the cpu priority level block
// Assumes: classic wishbone, one ack per request
// Notes: register rows in a table, interrupt cases by hand
`timescale 1ns/1ns
module cpu_priority_level_control_bench;
	import prio_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [15:0] d;
		logic [15:0] r;
		logic [3:0] l;
		logic b;
	} row_t;
	logic clk_i, rst_i, cyc, stb, we, ack, irq, src, blk;
	logic wm, ws, ten, mreq, sreq, take;
	logic [7:0] adr;
	logic [3:0] sel, sel_w;
	logic [31:0] wdat, rdat, q;
	logic [2:0] ilvl;
	logic [3:0] lvl;
	int bad_count, cmp_count, cyc_n;
	row_t rows [10];

	cpu_priority_level_control dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .master_req_i(mreq),
		.slave_req_i(sreq), .irq_take_i(take), .irq_o(irq),
		.irq_level_o(ilvl), .irq_src_o(src), .cpu_level_o(lvl),
		.user_block_o(blk));
	irq_partner part_u (.clk_i(clk_i), .rst_i(rst_i), .want_m_i(wm),
		.want_s_i(ws), .take_en_i(ten), .irq_i(irq), .master_req_o(mreq),
		.slave_req_o(sreq), .take_o(take));

	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk

	// holds the request until ack is seen high 1 ns after a rising edge, then for one more edge
	task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= sel_w;
		wdat <= {16'h0, d};
		// look just after each edge so ack is not raced by its own launch
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h1, 32'h0);
		// the request still stands at the edge that ends the ack cycle
		@(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		#1;
	endtask : wb

	task irq_case(input logic [15:0] pw, input logic [15:0] lw,
		input logic [15:0] cw, input logic m, input logic s,
		input logic e_irq, input logic [2:0] e_lvl, input logic e_src);
		wb(1'b1, 8'h08, pw);
		wb(1'b1, 8'h00, lw);
		wb(1'b1, 8'h04, cw);
		@(posedge clk_i);
		wm <= m;
		ws <= s;
		repeat (2) @(posedge clk_i);
		#1;
		chk(32'(irq), 32'(e_irq));
		chk(32'(ilvl), 32'(e_lvl));
		if (e_irq) chk(32'(src), 32'(e_src));
		@(posedge clk_i);
		wm <= 1'b0;
		ws <= 1'b0;
	endtask : irq_case

	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		{cyc, stb, we, wm, ws, ten} = '0;
		adr = '0;
		sel = '0;
		sel_w = 4'h3;
		wdat = '0;
		rst_i = 1'b1;
		rows = '{'{8'h00, 16'h00a0, 16'h00a0, 4'h5, 1'b0},
			'{8'h04, 16'h0008, 16'h0008, 4'hd, 1'b1},
			'{8'h04, 16'h0000, 16'h0000, 4'h5, 1'b0},
			'{8'h00, 16'h00e0, 16'h00e0, 4'h7, 1'b1},
			'{8'h00, 16'h0000, 16'h0000, 4'h0, 1'b0},
			'{8'h08, 16'hffff, 16'h0770, 4'h0, 1'b0},
			'{8'h14, 16'hffff, 16'h0000, 4'h0, 1'b0},
			'{8'h0c, 16'h8000, 16'h8000, 4'h0, 1'b0},
			'{8'h00, 16'h00c0, 16'h0000, 4'h0, 1'b0},
			'{8'h0c, 16'h0000, 16'h0000, 4'h0, 1'b0}};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk(32'(lvl), 32'h0);
		wb(1'b0, 8'h08, 16'h0);
		chk(q, 32'h0440);
		foreach (rows[i]) begin
			wb(1'b1, rows[i].a, rows[i].d);
			wb(1'b0, rows[i].a, 16'h0);
			chk(q, {16'h0, rows[i].r});
			chk(32'(lvl), 32'(rows[i].l));
			chk(32'(blk), 32'(rows[i].b));
		end
		// upper byte lane only: the slave field in the low lane survives
		sel_w = 4'h2;
		wb(1'b1, 8'h08, 16'h0000);
		sel_w = 4'h3;
		wb(1'b0, 8'h08, 16'h0);
		chk(q, 32'h0070);
		irq_case(16'h0350, 16'h0000, 16'h0, 1, 1, 1, 3'h5, 1);
		irq_case(16'h0350, 16'h00a0, 16'h0, 1, 1, 0, 3'h0, 0);
		irq_case(16'h0050, 16'h0000, 16'h0, 1, 0, 0, 3'h0, 0);
		irq_case(16'h0770, 16'h0000, 16'h8, 1, 1, 0, 3'h0, 0);
		irq_case(16'h0770, 16'h00c0, 16'h0, 1, 0, 1, 3'h7, 0);
		irq_case(16'h0440, 16'h0000, 16'h0, 1, 1, 1, 3'h4, 0);
		irq_case(16'h0770, 16'h00e0, 16'h0, 1, 1, 0, 3'h0, 0);
		wb(1'b1, 8'h00, 16'h0);
		wb(1'b1, 8'h08, 16'h0440);
		@(posedge clk_i);
		ten <= 1'b1;
		wm <= 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		chk(32'(lvl), 32'h4);
		chk(32'(irq), 32'h0);
		// level status: level 4, nothing blocked, no interrupt left
		wb(1'b0, 8'h10, 16'h0);
		chk(q, 32'h0004);
		// reset in mid-run puts the level back to zero
		@(posedge clk_i);
		rst_i <= 1'b1;
		ten <= 1'b0;
		wm <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk(32'(lvl), 32'h0);
		chk(32'(irq), 32'h0);
		wb(1'b0, 8'h08, 16'h0);
		chk(q, 32'h0440);
		print_verdict();
	end
endmodule : cpu_priority_level_control_bench
